// [design/lfs_supervisor.sv]
// Lamp fault supervisor: start-up gating, strike ramp, run regulation,
// fault handling with retries, EMI and overdrive control, byte register file.
// Assumes a serial-bus front end that presents one byte access per strobe and
// a one-clock lamp tick per lamp-frequency cycle, all synchronous to i_clk_sys.
`timescale 1ns/100ps
`include "lfs_map.svh"

module lfs_supervisor
   import lfs_pkg::*;
#(
   parameter int STRIKE_BASE = `LFS_STRIKE_BASE,
   parameter int RETRY_WAIT  = `LFS_RETRY_WAIT,
   parameter int OD_STEP     = `LFS_OD_STEP
) (
   input  wire logic       i_clk_sys,
   input  wire logic       i_sys_rst,
   input  wire logic       i_lamp_tick,
   input  wire lfs_sense_t i_sense,
   input  wire logic       i_powerdown_pin,
   input  wire logic       i_step_pin,
   input  wire logic       i_overdrive_pin,
   input  wire logic [7:0] i_reg_addr,
   input  wire logic       i_reg_wr,
   input  wire logic       i_reg_rd,
   input  wire logic [7:0] i_reg_wdata,
   output logic [7:0]      o_reg_rdata,
   output logic [7:0]      o_gate_duty,
   output logic            o_gate_enable,
   output logic            o_fault,
   output logic            o_sample_strobe,
   output logic [9:0]      o_regulation_threshold,
   output logic            o_overdrive_active,
   output lfs_emi_t        o_emi
);

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [7:0]  burst_duty_code;
   logic [7:0]  lamp_current_ctrl;
   logic [7:0]  softstart_profile [0:3];
   logic [7:0]  control_first;
   logic [7:0]  control_second;
   logic [7:0]  emi_control;
   logic [7:0]  overdrive_control;
   logic [7:0]  user_bytes [0:7];
   logic [4:0]  latched;            // Status bits 1..5
   lfs_state_t  state;
   logic [15:0] cycle_cnt;
   logic [3:0]  retry_cnt;
   logic [6:0]  ov_cnt;
   logic [2:0]  sample_cnt;
   logic [25:0] od_cnt;
   logic        od_expired;
   logic        low_prev;
   logic        high_prev;

   function automatic logic is_addr(input logic [7:0] a, input logic [7:0] ref_a);
      return a == ref_a;
   endfunction

   // Lamp cycles before strike or lamp-out timeout
   function automatic logic [15:0] strike_limit(input logic [7:0] ssp);
      logic [1:0] sel;
      sel = {ssp[`LFS_BIT_STO_HI], ssp[`LFS_BIT_STO_LO]};
      return 16'(STRIKE_BASE << sel);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Status and clearing events
   logic supply_good;
   logic mon_crossed;
   logic ch_disabled;
   logic pd_sw;
   logic clear_evt;
   logic tick_ov_full;
   logic strike_to;
   logic lamp_out;
   logic soft_fault;
   logic retry_allowed;
   logic [3:0] tick_div;

   assign supply_good = i_sense.supply_ok & i_sense.supply_low_ok & ~i_sense.supply_high;
   assign mon_crossed = (low_prev != i_sense.supply_low_ok) | (high_prev != i_sense.supply_high);
   assign ch_disabled = lamp_current_ctrl[`LFS_BIT_CH_DISABLE];
   assign pd_sw       = control_second[`LFS_BIT_PD_SW];
   assign clear_evt   = ~supply_good | mon_crossed | i_powerdown_pin | pd_sw | ch_disabled;
   assign tick_ov_full = i_lamp_tick & i_sense.overvoltage & (ov_cnt == `LFS_OV_PERSIST - 7'h01);
   assign strike_to   = (state == LFS_STRIKE) & i_lamp_tick & ~i_sense.current
                        & (cycle_cnt >= strike_limit(softstart_profile[0]) - 16'h0001);
   assign lamp_out    = (state == LFS_RUN) & i_lamp_tick & ~i_sense.current
                        & (cycle_cnt >= strike_limit(softstart_profile[0]) - 16'h0001);
   assign soft_fault  = strike_to | lamp_out | ((state == LFS_STRIKE) & tick_ov_full);
   assign retry_allowed = ~control_first[`LFS_BIT_RETRY_OFF] & (retry_cnt < `LFS_RETRY_MAX);
   assign tick_div    = 4'h1 << {control_second[`LFS_BIT_SR_HI], control_second[`LFS_BIT_SR_LO]};

   // Tracks the comparators through reset too, so release shows no false crossing
   always_ff @(posedge i_clk_sys) begin
      low_prev  <= i_sense.supply_low_ok;
      high_prev <= i_sense.supply_high;
   end

   // Overvoltage persistence counter, saturating at the latch threshold
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         ov_cnt <= 7'h00;
      end else if (i_lamp_tick) begin
         if (!i_sense.overvoltage) begin
            ov_cnt <= 7'h00;
         end else if (ov_cnt != `LFS_OV_PERSIST) begin
            ov_cnt <= ov_cnt + 7'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel state machine
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         state     <= LFS_OFF;
         cycle_cnt <= 16'h0000;
         retry_cnt <= 4'h0;
      end else if (clear_evt) begin
         state     <= LFS_OFF;
         cycle_cnt <= 16'h0000;
         retry_cnt <= 4'h0;
      end else begin
         case (state)
            LFS_OFF: begin
               state     <= LFS_STRIKE;
               cycle_cnt <= 16'h0000;
            end
            LFS_STRIKE, LFS_RUN: begin
               if (i_sense.overcurrent) begin
                  state <= LFS_FAULT;
               end else if (soft_fault) begin
                  cycle_cnt <= 16'h0000;
                  if (control_first[`LFS_BIT_SOFT_NOSHUT]) begin
                     state <= LFS_STRIKE;
                  end else if (retry_allowed) begin
                     state     <= LFS_RETRY;
                     retry_cnt <= retry_cnt + 4'h1;
                  end else begin
                     state <= LFS_FAULT;
                  end
               end else if (state == LFS_STRIKE && i_lamp_tick && i_sense.current) begin
                  state     <= LFS_RUN;
                  cycle_cnt <= 16'h0000;
               end else if (i_lamp_tick) begin
                  if (state == LFS_RUN && i_sense.current) begin
                     cycle_cnt <= 16'h0000;
                  end else begin
                     cycle_cnt <= cycle_cnt + 16'h0001;
                  end
               end
            end
            LFS_RETRY: begin
               if (i_lamp_tick) begin
                  if (cycle_cnt == 16'(RETRY_WAIT - 1)) begin
                     state     <= LFS_STRIKE;
                     cycle_cnt <= 16'h0000;
                  end else begin
                     cycle_cnt <= cycle_cnt + 16'h0001;
                  end
               end
            end
            LFS_FAULT: state <= LFS_FAULT;
            default:   state <= LFS_OFF;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gate drive: strike ramp and run regulation
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         sample_cnt      <= 3'h0;
         o_sample_strobe <= 1'b0;
      end else begin
         o_sample_strobe <= 1'b0;
         if (i_lamp_tick) begin
            if ({1'b0, sample_cnt} >= tick_div - 4'h1) begin
               sample_cnt      <= 3'h0;
               o_sample_strobe <= 1'b1;
            end else begin
               sample_cnt <= sample_cnt + 3'h1;
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_gate_duty   <= 8'h00;
         o_gate_enable <= 1'b0;
      end else if (clear_evt || soft_fault || i_sense.overcurrent
                   || !(state == LFS_STRIKE || state == LFS_RUN)) begin
         o_gate_duty   <= 8'h00;
         o_gate_enable <= 1'b0;
      end else begin
         o_gate_enable <= 1'b1;
         if (state == LFS_STRIKE && i_lamp_tick) begin
            if (!i_sense.overvoltage && o_gate_duty != `LFS_DUTY_MAX) begin
               o_gate_duty <= o_gate_duty + 8'h01;
            end
         end else if (state == LFS_RUN && o_sample_strobe) begin
            // Overvoltage always backs off, even below target current
            if ((i_sense.overvoltage || i_sense.above_target) && o_gate_duty != 8'h00) begin
               o_gate_duty <= o_gate_duty - 8'h01;
            end else if (!i_sense.overvoltage && !i_sense.above_target
                         && o_gate_duty != `LFS_DUTY_MAX) begin
               o_gate_duty <= o_gate_duty + 8'h01;
            end
         end
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_fault <= 1'b0;
      end else begin
         o_fault <= (state == LFS_FAULT) & ~clear_evt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // EMI options and overdrive
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_emi <= '0;
      end else begin
         o_emi.dither_range       <= emi_control[1:0];
         o_emi.dither_enable      <= emi_control[1:0] != 2'b00;
         o_emi.dither_profile_sel <= emi_control[`LFS_BIT_DITHER_PROF];
         o_emi.freq_select        <= emi_control[7:5];
         o_emi.step_enable        <= (emi_control[1:0] == 2'b00)
                                     & (emi_control[`LFS_BIT_STEP_EN] | i_step_pin);
      end
   end

   logic od_request;
   logic [25:0] od_limit;
   assign od_request = overdrive_control[`LFS_BIT_OD_EN] | i_overdrive_pin;
   assign od_limit   = 26'(OD_STEP * int'(overdrive_control[7:4]));

   // A zero timeout field leaves overdrive on indefinitely
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         od_cnt     <= 26'h0000000;
         od_expired <= 1'b0;
      end else if (!od_request || overdrive_control[7:4] == 4'h0) begin
         od_cnt     <= 26'h0000000;
         od_expired <= 1'b0;
      end else if (i_lamp_tick && !od_expired) begin
         if (od_cnt >= od_limit - 26'h0000001) begin
            od_expired <= 1'b1;
         end else begin
            od_cnt <= od_cnt + 26'h0000001;
         end
      end
   end

   // Nominal scaled 100..35 percent by the trim code, then by (9+level)/8
   function automatic logic [9:0] target(input logic [4:0] lc, input logic od, input logic [2:0] lvl);
      logic [19:0] base;
      logic [19:0] boosted;
      base    = (20'(`LFS_NOMINAL_TARGET) * (20'd3100 - 20'd65 * 20'(lc))) / 20'd3100;
      boosted = (base * (20'd9 + 20'(lvl))) >> 3;
      return od ? boosted[9:0] : base[9:0];
   endfunction

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_overdrive_active     <= 1'b0;
         o_regulation_threshold <= `LFS_NOMINAL_TARGET;
      end else begin
         o_overdrive_active     <= od_request & ~od_expired;
         o_regulation_threshold <= target(lamp_current_ctrl[4:0], od_request & ~od_expired,
                                          overdrive_control[2:0]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file
   logic rd_status;
   logic [4:0] set_bits;
   assign rd_status = i_reg_rd & is_addr(i_reg_addr, `LFS_ADDR_STATUS);
   assign set_bits  = {i_sense.overcurrent & (state == LFS_STRIKE || state == LFS_RUN),
                       lamp_out,
                       tick_ov_full,
                       strike_to,
                       (state != LFS_FAULT) & (i_sense.overcurrent & (state == LFS_STRIKE || state == LFS_RUN)
                                               | soft_fault & ~retry_allowed
                                                 & ~control_first[`LFS_BIT_SOFT_NOSHUT])};

   // New events win over a clearing read in the same cycle
   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst || clear_evt) begin
         latched <= 5'h00;
      end else if (rd_status) begin
         latched <= set_bits;
      end else begin
         latched <= latched | set_bits;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         burst_duty_code   <= `LFS_RST_BURST;
         lamp_current_ctrl <= `LFS_RST_LAMP_CTRL;
         softstart_profile <= '{`LFS_RST_SSP_A, `LFS_RST_SSP_B, `LFS_RST_SSP_C, `LFS_RST_SSP_D};
         control_first     <= `LFS_RST_CTRL1;
         control_second    <= `LFS_RST_CTRL2;
         emi_control       <= `LFS_RST_EMI;
         overdrive_control <= `LFS_RST_OVERDRIVE;
      end else if (i_reg_wr) begin
         // Status and reserved bytes take no write
         case (i_reg_addr)
            `LFS_ADDR_BURST:     burst_duty_code   <= i_reg_wdata;
            `LFS_ADDR_LAMP_CTRL: lamp_current_ctrl <= i_reg_wdata;
            `LFS_ADDR_SSP_A:     softstart_profile[0] <= i_reg_wdata;
            `LFS_ADDR_SSP_B:     softstart_profile[1] <= i_reg_wdata;
            `LFS_ADDR_SSP_C:     softstart_profile[2] <= i_reg_wdata;
            `LFS_ADDR_SSP_D:     softstart_profile[3] <= i_reg_wdata;
            `LFS_ADDR_CTRL1:     control_first     <= i_reg_wdata;
            `LFS_ADDR_CTRL2:     control_second    <= i_reg_wdata;
            `LFS_ADDR_EMI:       emi_control       <= i_reg_wdata;
            `LFS_ADDR_OVERDRIVE: overdrive_control <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_user
         always_ff @(posedge i_clk_sys) begin
            if (i_sys_rst) begin
               user_bytes[gi] <= `LFS_RST_USER;
            end else if (i_reg_wr && is_addr(i_reg_addr, 8'(`LFS_ADDR_USER_BASE + gi))) begin
               user_bytes[gi] <= i_reg_wdata;
            end
         end
      end
   endgenerate

   always_ff @(posedge i_clk_sys) begin
      if (i_sys_rst) begin
         o_reg_rdata <= 8'h00;
      end else if (i_reg_rd) begin
         case (i_reg_addr)
            `LFS_ADDR_STATUS:    o_reg_rdata <= {i_sense.supply_high, i_sense.supply_low_ok,
                                                 latched[4:0], state == LFS_FAULT};
            `LFS_ADDR_BURST:     o_reg_rdata <= burst_duty_code;
            `LFS_ADDR_LAMP_CTRL: o_reg_rdata <= lamp_current_ctrl;
            `LFS_ADDR_SSP_A:     o_reg_rdata <= softstart_profile[0];
            `LFS_ADDR_SSP_B:     o_reg_rdata <= softstart_profile[1];
            `LFS_ADDR_SSP_C:     o_reg_rdata <= softstart_profile[2];
            `LFS_ADDR_SSP_D:     o_reg_rdata <= softstart_profile[3];
            `LFS_ADDR_CTRL1:     o_reg_rdata <= control_first;
            `LFS_ADDR_CTRL2:     o_reg_rdata <= control_second;
            `LFS_ADDR_EMI:       o_reg_rdata <= emi_control;
            `LFS_ADDR_OVERDRIVE: o_reg_rdata <= overdrive_control;
            default: o_reg_rdata <= (i_reg_addr >= `LFS_ADDR_USER_BASE) ? user_bytes[i_reg_addr[2:0]] : 8'h00;
         endcase
      end
   end

endmodule

// [design/lfs_map.svh]
// Constants for the lamp fault supervisor: register offsets, field positions,
// reset values and lamp-cycle counts. Included by the design; the package holds only types.
// Operation
// - Lamp stays off unless supply, low monitor and high monitor are all good.
// - Strike ramps gate duty upward until lamp current is sensed.
// - During strike, overvoltage sense stops further duty increase.
// - No current before the strike timeout enters fault handling; timeout from profile A.
// - Overvoltage event during strike turns gates off and enters fault handling.
// - In run, duty regulates lamp current and never pushes past overvoltage.
// - Lamp current sample rate is chosen by two bits in control_second.
// - Current below lamp-out reference for strike timeout in run is a fault.
// - Auto retry makes up to 14 restrikes, except on overcurrent.
// - Retry attempts are separated by 1024 lamp cycles.
// - Overcurrent faults the channel at once with no retry.
// - Fault persists until lockout, monitor crossing, powerdown pin, powerdown bit or disable.
// - In fault the indicator output asserts and the channel stays disabled.
// - A configuration bit selects whether soft faults shut the channel down.
// - Real-time status bits follow present fault and monitor conditions.
// - Nonzero dither range enables dither of 1.5, 3 or 6 percent, disables stepping.
// - Dither profile bit picks triangle or pseudorandom; frequency select sets rate.
// - With dither off, step bit or step pin enables stepping by frequency select.
// - Overdrive raises current target 112.5 to 200 percent in 12.5 percent steps.
// - Optional overdrive timer turns overdrive off after a programmable delay.
// - Reading channel_status clears its latched bits regardless of condition.
// - Latched overvoltage sets only after 64 consecutive overvoltage lamp cycles.
// - Bit 5 of lamp_current_ctrl disables the channel when 1.
// - Writes to channel_status have no effect.
`ifndef LFS_MAP_SVH
`define LFS_MAP_SVH

`define LFS_ADDR_STATUS      8'hE0
`define LFS_ADDR_RESERVED_E1_E1     8'hE1
`define LFS_ADDR_BURST       8'hE2
`define LFS_ADDR_LAMP_CTRL   8'hE3
`define LFS_ADDR_SSP_A       8'hF0
`define LFS_ADDR_SSP_B       8'hF1
`define LFS_ADDR_SSP_C       8'hF2
`define LFS_ADDR_SSP_D       8'hF3
`define LFS_ADDR_CTRL1       8'hF4
`define LFS_ADDR_CTRL2       8'hF5
`define LFS_ADDR_EMI         8'hF6
`define LFS_ADDR_OVERDRIVE   8'hF7
`define LFS_ADDR_USER_BASE   8'hF8

`define LFS_RST_BURST        8'h00
`define LFS_RST_LAMP_CTRL    8'h1F
`define LFS_RST_SSP_A        8'h21
`define LFS_RST_SSP_B        8'h43
`define LFS_RST_SSP_C        8'h65
`define LFS_RST_SSP_D        8'h77
`define LFS_RST_CTRL1        8'h00
`define LFS_RST_CTRL2        8'h08
`define LFS_RST_EMI          8'h00
`define LFS_RST_OVERDRIVE    8'h00
`define LFS_RST_USER         8'h00

// Field positions
`define LFS_BIT_CH_DISABLE   5
`define LFS_BIT_STO_LO       4
`define LFS_BIT_STO_HI       7
`define LFS_BIT_RETRY_OFF    5
`define LFS_BIT_SOFT_NOSHUT  4
`define LFS_BIT_SR_LO        3
`define LFS_BIT_SR_HI        4
`define LFS_BIT_PD_SW        7
`define LFS_BIT_STEP_EN      4
`define LFS_BIT_DITHER_PROF  2
`define LFS_BIT_OD_EN        3

// Retry limit, lamp-cycle counts, duty limit and nominal target
`define LFS_RETRY_MAX        4'hE
`define LFS_RETRY_WAIT       1024
`define LFS_OV_PERSIST       7'h40
`define LFS_STRIKE_BASE      1024
`define LFS_OD_STEP          4200000
`define LFS_DUTY_MAX         8'hFF
`define LFS_NOMINAL_TARGET   10'h100

`endif

// [design/lfs_pkg.sv]
// Types shared by the lamp fault supervisor.
// Assumes lfs_map.svh is on the include path.
package lfs_pkg;
   typedef enum logic [2:0] {LFS_OFF, LFS_STRIKE, LFS_RUN, LFS_RETRY, LFS_FAULT} lfs_state_t;

   typedef struct packed {
      logic supply_ok;      // Above lockout level
      logic supply_low_ok;  // Low monitor above threshold
      logic supply_high;    // High monitor above threshold
      logic current;        // Lamp current above lamp-out reference
      logic above_target;   // Lamp current above regulation threshold
      logic overvoltage;
      logic overcurrent;
   } lfs_sense_t;

   typedef struct packed {
      logic       dither_enable;
      logic [1:0] dither_range;
      logic       dither_profile_sel;
      logic       step_enable;
      logic [2:0] freq_select;
   } lfs_emi_t;
endpackage

// [verif/lfs_assertions.sv]
// Port assertions for lfs_supervisor.
// Bound from the testbench; one clock domain.
`timescale 1ns/100ps
module lfs_assertions
   import lfs_pkg::*;
(
   input wire logic       i_clk_sys,
   input wire logic       i_sys_rst,
   input wire logic       i_lamp_tick,
   input wire lfs_sense_t i_sense,
   input wire logic       i_powerdown_pin,
   input wire logic [7:0] i_reg_addr,
   input wire logic       i_reg_wr,
   input wire logic       i_reg_rd,
   input wire logic [7:0] i_reg_wdata,
   input wire logic [7:0] o_reg_rdata,
   input wire logic [7:0] o_gate_duty,
   input wire logic       o_gate_enable,
   input wire logic       o_fault,
   input wire logic       o_sample_strobe
);
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (i_sys_rst);
   sequence s_bad;
      !(i_sense.supply_ok && i_sense.supply_low_ok && !i_sense.supply_high);
   endsequence
   sequence s_dis;
      i_reg_wr && i_reg_addr == 8'hE3 && i_reg_wdata[5];
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   fault_gate_off_a: assert property (o_fault |-> !o_gate_enable)
      else $error("gate on while faulted");
   supply_gate_off_a: assert property (s_bad [*3] |-> !o_gate_enable)
      else $error("gate on with supply bad");
   pd_clears_a: assert property (i_powerdown_pin [*3] |-> !o_fault && !o_gate_enable)
      else $error("powerdown did not clear");
   overcurrent_trip_a: assert property (o_gate_enable && i_sense.overcurrent && !i_powerdown_pin
      |-> ##[1:3] o_fault) else $error("overcurrent not faulted");
   strobe_tick_a: assert property (o_sample_strobe |-> $past(i_lamp_tick))
      else $error("strobe without tick");
   ov_ramp_stop_a: assert property (i_sense.overvoltage |=> o_gate_duty <= $past(o_gate_duty))
      else $error("duty rose under overvoltage");
   status_rt_a: assert property (i_reg_rd && i_reg_addr == 8'hE0 |=>
      o_reg_rdata[7:6] == {$past(i_sense.supply_high), $past(i_sense.supply_low_ok)})
      else $error("monitor status wrong");
   disable_bit_a: assert property (s_dis |-> ##3 !o_gate_enable && !o_fault)
      else $error("disable bit ignored");
endmodule

// [verif/lfs_lamp_model.sv]
// Power stage and lamp: tick every 4 clocks, lamp lit once duty reaches strike level.
// Supply and fault levels come from the bench.
`timescale 1ns/100ps
module lfs_lamp_model
   import lfs_pkg::*;
(
   input  wire logic [7:0] i_gate_duty,
   input  wire logic       i_gate_enable,
   input  wire logic       i_clk_sys,
   input  wire logic [7:0] i_strike_at,
   input  wire logic [2:0] i_supply,
   input  wire logic [1:0] i_faults,
   output logic            o_lamp_tick,
   output lfs_sense_t      o_sense
);
   logic [1:0] div = 2'h0;
   logic       lit;
   always @(posedge i_clk_sys) div <= div + 2'h1;
   assign o_lamp_tick = (div == 2'h3);
   // Lamp conducts only with gates on
   assign lit = i_gate_enable && (i_gate_duty >= i_strike_at);
   assign o_sense = {i_supply, lit, lit && (i_gate_duty > i_strike_at + 8'h04), i_faults};
endmodule

// [verif/testbench.sv]
// Self-checking bench for lfs_supervisor with shortened lamp-cycle counts.
// Drives at rising edges, checks at falling edges.
`timescale 1ns/100ps
module testbench;
   import lfs_pkg::*;
   logic clk = 0, rst = 1, pd = 0, step = 0, odp = 0, wr = 0, rd = 0, gen, flt, stb, oda, tick, g;
   logic [7:0] adr = 0, wd = 0, rdat, duty, d, sat = 8'h10;
   logic [9:0] thr;
   logic [2:0] sup = 3'h6;
   logic [1:0] flts = 0;
   lfs_sense_t sense;
   lfs_emi_t   emi;
   int seed = 38836, fails = 0, n_tests = 0, n, k;
   logic [7:0] ra [14] = '{8'hE0, 8'hE1, 8'hE2, 8'hE3, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'hF4, 8'hF5, 8'hF6, 8'hF7, 8'hF8, 8'h10};
   logic [7:0] rv [14] = '{8'h40, 8'h00, 8'h00, 8'h1F, 8'h21, 8'h43, 8'h65, 8'h77, 8'h00, 8'h08, 8'h00, 8'h00, 8'h00, 8'h00};
   always #25 clk = ~clk;
   lfs_supervisor #(.STRIKE_BASE(64), .RETRY_WAIT(8), .OD_STEP(10)) DUT (.i_clk_sys(clk), .i_sys_rst(rst),
      .i_lamp_tick(tick), .i_sense(sense), .i_powerdown_pin(pd), .i_step_pin(step), .i_overdrive_pin(odp),
      .i_reg_addr(adr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdat), .o_gate_duty(duty),
      .o_gate_enable(gen), .o_fault(flt), .o_sample_strobe(stb), .o_regulation_threshold(thr),
      .o_overdrive_active(oda), .o_emi(emi));
   lfs_lamp_model LAMP (.i_gate_duty(duty), .i_gate_enable(gen), .i_clk_sys(clk), .i_strike_at(sat),
      .i_supply(sup), .i_faults(flts), .o_lamp_tick(tick), .o_sense(sense));
   ////////////////////////////////////////////////////////////////////////////
   function automatic lfs_emi_t exp_emi(input logic [7:0] v, input logic p);
      return {v[1:0] != 2'h0, v[1:0], v[2], v[1:0] == 2'h0 && (v[4] || p), v[7:5]};
   endfunction
   function automatic logic [10:0] exp_thr(input logic [2:0] l);
      return {1'b1, 10'(32 * (9 + l))};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk) begin adr <= a; wd <= v; wr <= 1'b1; end
      @(posedge clk) wr <= 1'b0;
      @(negedge clk);
   endtask
   task automatic rreg(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk) begin adr <= a; rd <= 1'b1; end
      @(posedge clk) rd <= 1'b0;
      @(negedge clk) v = rdat;
   endtask
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      sat <= 8'h08 + 8'($random(seed) & 31);
      wreg(8'hE0, 8'hFF);
      wreg(8'hE1, 8'hFF);
      for (k = 0; k < 14; k++) begin rreg(ra[k], d); chk(d, rv[k]); end
      for (k = 0; k < 8; k++) begin
         d = 8'($random(seed));
         d[1:0] = k[1:0];
         @(posedge clk) step <= d[3];
         wreg(8'hF6, d);
         @(negedge clk); // Output copy lags the register by one clock
         chk(emi, exp_emi(d, d[3]));
      end
      wreg(8'hF6, 8'h00);
      $display("test registers done");
      repeat (300) @(negedge clk);
      rreg(8'hE0, d); chk({d, 7'h0, gen}, 16'h4001);
      chk(8'(duty - sat) & 8'hFE, 8'h04);
      @(posedge clk) flts <= 2'h2;
      repeat (24) @(negedge clk);
      @(posedge clk) flts <= 2'h1;
      for (k = 0; k < 10 && flt !== 1'b1; k++) @(negedge clk);
      chk({flt, gen}, 2'b10);
      @(posedge clk) begin flts <= 2'h0; sat <= 8'hFF; end
      rreg(8'hE0, d); chk(d, 8'h63);
      rreg(8'hE0, d); chk(d, 8'h41);
      @(posedge clk) pd <= 1'b1;
      wreg(8'hF4, 8'h20);
      @(posedge clk) pd <= 1'b0;
      rreg(8'hE0, d); chk({d, flt}, 9'h080);
      for (k = 0; k < 2000 && flt !== 1'b1; k++) @(negedge clk);
      rreg(8'hE0, d); chk(d, 8'h47);
      wreg(8'hE3, 8'h3F);
      repeat (3) @(negedge clk);
      chk({flt, gen}, 2'b00);
      $display("test faults done");
      wreg(8'hF4, 8'h00);
      g = 1'b0;
      n = 0;
      wreg(8'hE3, 8'h1F);
      for (k = 0; k < 9000 && flt !== 1'b1; k++) begin
         @(negedge clk);
         if (gen === 1'b1 && g === 1'b0) n++;
         g = gen;
      end
      chk(n, 15);
      @(posedge clk) sup <= 3'h4;
      repeat (4) @(negedge clk);
      chk({flt, gen}, 2'b00);
      wreg(8'hF4, 8'h30);
      @(posedge clk) sup <= 3'h6;
      repeat (700) @(negedge clk);
      rreg(8'hE0, d); chk({d, flt}, 9'h088);
      @(posedge clk) sat <= 8'h10;
      $display("test retries done");
      wreg(8'hE3, 8'h00);
      for (k = 0; k < 8; k++) begin
         wreg(8'hF7, 8'h08 | 8'(k));
         repeat (2) @(negedge clk);
         chk({oda, thr}, exp_thr(k[2:0]));
      end
      wreg(8'hF7, 8'h18);
      repeat (60) @(negedge clk);
      chk(oda, 1'b0);
      wreg(8'hF7, 8'h00);
      @(posedge clk) odp <= 1'b1;
      repeat (3) @(negedge clk);
      chk({oda, thr}, exp_thr(3'h0));
      $display("test overdrive done");
      print_verdict;
   end
   initial begin
      #2000000;
      fails++;
      print_verdict;
   end
endmodule
bind lfs_supervisor lfs_assertions CHK (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_lamp_tick(i_lamp_tick),
   .i_sense(i_sense), .i_powerdown_pin(i_powerdown_pin), .i_reg_addr(i_reg_addr), .i_reg_wr(i_reg_wr),
   .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata), .o_gate_duty(o_gate_duty),
   .o_gate_enable(o_gate_enable), .o_fault(o_fault), .o_sample_strobe(o_sample_strobe));
